// ==== hw/bdir_apb_decode.sv ====
// apb address decode and strobes for the interrupt register block
// assumes a single-cycle apb slave (pready always high)
`timescale 1ns/1ps
`default_nettype none
module bdir_apb_decode
  import bdir_pkg::*;
(
  input  wire logic [9:0] paddr_i,
  input  wire logic       psel_i,
  input  wire logic       penable_i,
  input  wire logic       pwrite_i,
  output logic            wr_ctrl_o,
  output logic            wr_clear_o,
  output logic            wr_mask_o,
  output logic            rd_status_o,
  output logic            rd_events_o,
  output logic            hit_o
);
  logic access;
  assign access      = psel_i & penable_i;
  // a misaligned byte address matches no register and answers with an error
  assign hit_o       = (paddr_i == BDIR_ADDR_CONTROL) | (paddr_i == BDIR_ADDR_STATUS) |
                       (paddr_i == BDIR_ADDR_CLEAR) | (paddr_i == BDIR_ADDR_EVENTS) |
                       (paddr_i == BDIR_ADDR_MASK);
  assign wr_ctrl_o   = access & pwrite_i & (paddr_i == BDIR_ADDR_CONTROL);
  assign wr_clear_o  = access & pwrite_i & (paddr_i == BDIR_ADDR_CLEAR);
  assign wr_mask_o   = access & pwrite_i & (paddr_i == BDIR_ADDR_MASK);
  assign rd_status_o = access & ~pwrite_i & (paddr_i == BDIR_ADDR_STATUS);
  assign rd_events_o = access & ~pwrite_i & (paddr_i == BDIR_ADDR_EVENTS);
endmodule : bdir_apb_decode
`default_nettype wire

// ==== hw/bdir_clear_seq.sv ====
// detects the write-1-then-write-0 clear sequence on the clear register
// assumes writes arrive as one-cycle strobes with their data bit
`timescale 1ns/1ps
`default_nettype none
module bdir_clear_seq
  import bdir_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  input  wire logic wr_i,
  input  wire logic bit_i,
  output logic      clear_o
);
  logic armed;
  // a lone 0 write never clears: it must follow a 1 write
  assign clear_o = wr_i & ~bit_i & armed;
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      armed <= 1'b0;
    else if (wr_i)
      armed <= bit_i;
  end
endmodule : bdir_clear_seq
`default_nettype wire

// ==== hw/bdir_pkg.sv ====
// package for the blend-done interrupt register block
// assumes an apb slave on a 200 MHz clock, byte-wide registers in low bits
package bdir_pkg;
  localparam logic [7:0] BDIR_OFS_CONTROL = 8'hB2;
  localparam logic [7:0] BDIR_OFS_STATUS  = 8'hB4;
  localparam logic [7:0] BDIR_OFS_CLEAR   = 8'hB6;
  localparam logic [7:0] BDIR_OFS_EVENTS  = 8'hC0;
  localparam logic [7:0] BDIR_OFS_MASK    = 8'hC4;
  // offsets above are word indices; one register per aligned word, byte address is four times the index
  localparam logic [9:0] BDIR_ADDR_CONTROL = {BDIR_OFS_CONTROL, 2'h0};
  localparam logic [9:0] BDIR_ADDR_STATUS  = {BDIR_OFS_STATUS, 2'h0};
  localparam logic [9:0] BDIR_ADDR_CLEAR   = {BDIR_OFS_CLEAR, 2'h0};
  localparam logic [9:0] BDIR_ADDR_EVENTS  = {BDIR_OFS_EVENTS, 2'h0};
  localparam logic [9:0] BDIR_ADDR_MASK    = {BDIR_OFS_MASK, 2'h0};
  localparam int         BDIR_BIT_ENABLE  = 0;
  localparam int         BDIR_BIT_MASKDIS = 4;
  localparam int         BDIR_BIT_STATUS  = 0;
  localparam int         BDIR_BIT_CLEAR   = 0;
  localparam logic [7:0] BDIR_CONTROL_RST = 8'h00;
  localparam logic [7:0] BDIR_CONTROL_WMASK = 8'h11;
  localparam logic [1:0] BDIR_EVT_RST     = 2'h0;
  localparam logic [1:0] BDIR_MASK_RST    = 2'h0;
  localparam logic       BDIR_IRQ_RST     = 1'h0;
  localparam logic [31:0] BDIR_PRDATA_RST = 32'h0000_0000;
endpackage : bdir_pkg

// ==== hw/bdir_top.sv ====
// blend-done interrupt registers: control, status, clear over apb
// assumes the blend engine gives a one-cycle done pulse on blend_done_i
// Notes on behaviour
// - mask-disable bit set bypasses the mask
// - mask-disable bit clear keeps mask in force
// - status bit 0 reads 1 after interrupt
// - status reads 0 until an interrupt occurs
// - status is read-only, writes ignored
// - reserved bits read as zero
// - bit 4 disables mask, not enables it
`timescale 1ns/1ps
`default_nettype none
module bdir_top
  import bdir_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [9:0]  paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        blend_done_i,
  output logic             irq_o
);
  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic        wr_ctrl;
  logic        wr_clear;
  logic        wr_mask;
  logic        rd_status;
  logic        rd_events;
  logic        hit;
  logic        clear_now;
  logic [7:0]  control;
  logic        status;
  logic [1:0]  events;
  logic [1:0]  next_events;
  logic [1:0]  evt_seen;
  logic [1:0]  mask;
  logic [1:0]  next_mask;
  logic        next_irq;
  logic        raise;
  logic        mask_open;
  logic        evt_status_set;
  logic        evt_clear_set;
  logic [1:0]  evt_set;
  logic        sel_control;
  logic        sel_status;
  logic        sel_events;
  logic        sel_mask;
  logic        rd_setup;
  logic [7:0]  rd_byte;
  logic [31:0] next_prdata;

  bdir_apb_decode u_dec (
    .paddr_i     (paddr_i),
    .psel_i      (psel_i),
    .penable_i   (penable_i),
    .pwrite_i    (pwrite_i),
    .wr_ctrl_o   (wr_ctrl),
    .wr_clear_o  (wr_clear),
    .wr_mask_o   (wr_mask),
    .rd_status_o (rd_status),
    .rd_events_o (rd_events),
    .hit_o       (hit)
  );

  bdir_clear_seq u_clr (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .wr_i      (wr_clear),
    .bit_i     (pwdata_i[BDIR_BIT_CLEAR]),
    .clear_o   (clear_now)
  );

  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~hit;

  // ----------------------------------------------------------------
  // interrupt core
  // ----------------------------------------------------------------
  // bit 4 high opens the mask path
  assign mask_open = control[BDIR_BIT_MASKDIS];
  // the enable bit gates generation; with the mask disabled the event passes regardless
  assign raise     = blend_done_i & (control[BDIR_BIT_ENABLE] | mask_open);

  // only defined bits are writable, reserved stay zero
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      control <= BDIR_CONTROL_RST;
    else if (wr_ctrl)
      control <= pwdata_i[7:0] & BDIR_CONTROL_WMASK;
  end

  // set by event only, cleared by sequence; set wins
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      status <= 1'b0;
    else if (raise)
      status <= 1'b1;
    else if (clear_now)
      status <= 1'b0;
  end

  // ----------------------------------------------------------------
  // sticky event register, read-to-clear, and mask
  // ----------------------------------------------------------------
  assign evt_status_set = raise & ~status;
  assign evt_clear_set  = clear_now & status & ~raise;
  assign evt_set        = {evt_clear_set, evt_status_set};

  // a read clears only the bits its own data returned: an event landing
  // between the setup and the access cycle survives to the next read
  assign evt_seen = rd_events ? prdata_o[1:0] : 2'h0;

  // one sticky flag per event source; a new event beats the read clear
  for (genvar gi = 0; gi < 2; gi = gi + 1)
  begin : g_evt
    assign next_events[gi] = evt_set[gi] | (events[gi] & ~evt_seen[gi]);
  end

  assign next_mask = wr_mask ? pwdata_i[1:0] : mask;
  // irq comes from the next values, so the flop tracks events and mask with no lag
  assign next_irq  = |(next_events & next_mask);

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      events <= BDIR_EVT_RST;
    else
      events <= next_events;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      mask <= BDIR_MASK_RST;
    else
      mask <= next_mask;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      irq_o <= BDIR_IRQ_RST;
    else
      irq_o <= next_irq;
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  assign sel_control = paddr_i == BDIR_ADDR_CONTROL;
  assign sel_status  = paddr_i == BDIR_ADDR_STATUS;
  assign sel_events  = paddr_i == BDIR_ADDR_EVENTS;
  assign sel_mask    = paddr_i == BDIR_ADDR_MASK;
  // reserved bits and clear read zero
  assign rd_byte     = ({8{sel_control}} & control) |
                       ({8{sel_status}} & {7'h00, status}) |
                       ({8{sel_events}} & {6'h00, events}) |
                       ({8{sel_mask}} & {6'h00, mask});
  // data is loaded in the setup cycle so it stands through the whole access cycle
  assign rd_setup    = psel_i & ~penable_i & ~pwrite_i;
  assign next_prdata = rd_setup ? {24'h00_0000, rd_byte} : prdata_o;

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      prdata_o <= BDIR_PRDATA_RST;
    else
      prdata_o <= next_prdata;
  end

  // ----------------------------------------------------------------
  // status checks
  // ----------------------------------------------------------------
  // read data is checked one cycle after its setup, when the master takes it
  a_status_sets: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    blend_done_i && control[BDIR_BIT_ENABLE] |=> status)
    else $error("status not set after enabled event");

  a_bypass_mask: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    blend_done_i && control[BDIR_BIT_MASKDIS] |=> status)
    else $error("mask disable did not bypass");

  a_mask_holds: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !status && blend_done_i && control[7:0] == 8'h00 |=> !status)
    else $error("masked event raised status");

  a_status_quiet: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !status && !blend_done_i |=> !status)
    else $error("status rose without event");

  a_status_ro: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    psel_i && penable_i && pwrite_i && paddr_i == BDIR_ADDR_STATUS |=> status == $past(status) || $past(raise))
    else $error("status write had effect");

  a_bit4_disable: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !status && blend_done_i && !control[BDIR_BIT_ENABLE] && !control[BDIR_BIT_MASKDIS] |=> !status)
    else $error("bit 4 acted as mask enable");

  a_status_sticky: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    status && !clear_now |=> status)
    else $error("status dropped without clear");

  a_status_rd_keep: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rd_status && !raise |=> status == $past(status))
    else $error("status read changed status");

  a_status_rd_data: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rd_setup && sel_status |=> prdata_o == {31'h0, $past(status)})
    else $error("status read data wrong");

  // ----------------------------------------------------------------
  // clear sequence checks
  // ----------------------------------------------------------------
  // the arm flag lives in the clear detector; it is watched here beside its use
  a_clear_seq: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_clear && !pwdata_i[0] && !u_clr.armed && status |=> status)
    else $error("lone zero write cleared status");

  a_clear_done: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clear_now && !raise ##1 !blend_done_i |-> !status)
    else $error("clear sequence did not clear");

  a_lone_zero_keep: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_clear && !pwdata_i[BDIR_BIT_CLEAR] && !u_clr.armed |-> !clear_now)
    else $error("unarmed zero write gave a clear");

  a_armed_clears: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_clear && !pwdata_i[BDIR_BIT_CLEAR] && u_clr.armed |-> clear_now)
    else $error("armed zero write gave no clear");

  a_clear_reads_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rd_setup && paddr_i == BDIR_ADDR_CLEAR |=> prdata_o == 32'h0000_0000)
    else $error("clear register read not zero");

  // ----------------------------------------------------------------
  // register checks
  // ----------------------------------------------------------------
  // only the bus may change control and mask
  a_reserved_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (control & ~BDIR_CONTROL_WMASK) == 8'h00)
    else $error("reserved control bits set");

  a_ctrl_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_ctrl |=> control == ($past(pwdata_i[7:0]) & BDIR_CONTROL_WMASK))
    else $error("control write lost");

  a_ctrl_stable: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !wr_ctrl |=> control == $past(control))
    else $error("control changed without write");

  a_ctrl_read: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rd_setup && sel_control |=> prdata_o == {24'h00_0000, $past(control)})
    else $error("control read data wrong");

  a_mask_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_mask |=> mask == $past(pwdata_i[1:0]))
    else $error("mask write lost");

  a_mask_stable: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !wr_mask |=> mask == $past(mask))
    else $error("mask changed without write");

  a_rd_upper_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    prdata_o[31:8] == 24'h00_0000)
    else $error("upper read data not zero");

  // ----------------------------------------------------------------
  // event and irq checks
  // ----------------------------------------------------------------
  // irq must follow events and mask in the same cycle
  a_evt_rise: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    evt_status_set |=> events[0])
    else $error("status rise event lost");

  a_evt_clear_rise: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    evt_clear_set |=> events[1])
    else $error("status clear event lost");

  a_evt_sticky: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    events[0] && !rd_events |=> events[0])
    else $error("event dropped without read");

  a_evt_rd_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rd_events && prdata_o[0] && !evt_set[0] |=> !events[0])
    else $error("event read did not clear");

  a_irq_level: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    irq_o == |(events & mask))
    else $error("irq level wrong");
endmodule : bdir_top
`default_nettype wire

// ==== tb/bdir_engine_model.sv ====
// blend engine stand-in: one-cycle done pulse per request
// assumes go is driven from the bench clock domain
`timescale 1ns/1ps
`default_nettype none
module bdir_engine_model (
  input  wire logic ref_clk_i,
  input  wire logic go_i,
  output logic      done_o
);
  always_ff @(posedge ref_clk_i)
  begin
    done_o <= go_i;
  end
endmodule : bdir_engine_model
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the blend-done interrupt registers
// assumes apb master driven here, read results checked from a queue
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bdir_pkg::*;
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
  logic [9:0]  paddr = 10'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, done, irq;
  logic [32:0] exp_q[$];
  logic [31:0] seed = 32'd44245;
  int          fails = 0, checked = 0;
  always #2.5 clk = ~clk;
  bdir_top dut (.ref_clk_i(clk), .rst_n_i(rst_n), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .blend_done_i(done), .irq_o(irq));
  bdir_engine_model eng (.ref_clk_i(clk), .go_i(go), .done_o(done));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict();
    if (fails == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict
  // apb transfer; a read notes its expected {pslverr, prdata}
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d, input logic [32:0] e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    // callers pass the register index; each register takes one aligned word
    paddr <= {a, 2'h0};
    pwrite <= w;
    pwdata <= {24'h000000, d};
    if (!w) exp_q.push_back(e);
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic blend();
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : blend
  task automatic irq_is(input logic v);
    @(negedge clk);
    chk({32'h0, irq}, {32'h0, v});
  endtask : irq_is
  // ---------------------------------------------------------------
  // monitor: each completed read takes the oldest note
  // ---------------------------------------------------------------
  always @(posedge clk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk({pslverr, prdata}, exp_q.pop_front());
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    print_verdict();
  end
  initial
  begin
    logic [7:0] r;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    xfer(BDIR_OFS_CONTROL, 0, 8'h00, 33'h0);
    xfer(BDIR_OFS_STATUS, 0, 8'h00, 33'h0);
    xfer(BDIR_OFS_CLEAR, 0, 8'h00, 33'h0);
    repeat (4)
    begin
      r = 8'(xs());
      xfer(BDIR_OFS_CONTROL, 1, r, 33'h0);
      xfer(BDIR_OFS_CONTROL, 0, 8'h00, {25'h0, r & BDIR_CONTROL_WMASK});
    end
    xfer(BDIR_OFS_CONTROL, 1, 8'h00, 33'h0);
    blend();
    xfer(BDIR_OFS_STATUS, 0, 8'h00, 33'h0);
    xfer(BDIR_OFS_CONTROL, 1, 8'h10, 33'h0);
    blend();
    xfer(BDIR_OFS_STATUS, 0, 8'h00, 33'h1);
    xfer(BDIR_OFS_STATUS, 1, 8'h00, 33'h0);
    xfer(BDIR_OFS_STATUS, 0, 8'h00, 33'h1);
    // lone zero is ignored, one then zero clears
    xfer(BDIR_OFS_CLEAR, 1, 8'h00, 33'h0);
    xfer(BDIR_OFS_STATUS, 0, 8'h00, 33'h1);
    xfer(BDIR_OFS_CLEAR, 1, 8'h01, 33'h0);
    xfer(BDIR_OFS_CLEAR, 1, 8'h00, 33'h0);
    xfer(BDIR_OFS_STATUS, 0, 8'h00, 33'h0);
    xfer(BDIR_OFS_EVENTS, 0, 8'h00, 33'h3);
    xfer(BDIR_OFS_MASK, 1, 8'h01, 33'h0);
    xfer(BDIR_OFS_CONTROL, 1, 8'h01, 33'h0);
    blend();
    irq_is(1'b1);
    xfer(BDIR_OFS_EVENTS, 0, 8'h00, 33'h1);
    irq_is(1'b0);
    xfer(BDIR_OFS_CLEAR, 1, 8'h01, 33'h0);
    xfer(BDIR_OFS_CLEAR, 1, 8'h00, 33'h0);
    irq_is(1'b0);
    xfer(BDIR_OFS_EVENTS, 0, 8'h00, 33'h2);
    // second mask bit: only the clear event may raise irq
    xfer(BDIR_OFS_MASK, 0, 8'h00, 33'h1);
    xfer(BDIR_OFS_MASK, 1, 8'h02, 33'h0);
    blend();
    irq_is(1'b0);
    xfer(BDIR_OFS_CLEAR, 1, 8'h01, 33'h0);
    xfer(BDIR_OFS_CLEAR, 1, 8'h00, 33'h0);
    irq_is(1'b1);
    xfer(BDIR_OFS_EVENTS, 0, 8'h00, 33'h3);
    irq_is(1'b0);
    xfer(8'h10, 0, 8'h00, {1'b1, 32'h0});
    repeat (2) @(posedge clk);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
